// ==== design/timer_capture_match_pwm.sv ====
// Four 32-bit timer/counters and one seven-match PWM unit behind a word register port
//
// Functional notes
// - Four timers, each with 32-bit counter
// - 32-bit programmable prescaler ahead of counter
// - Timer mode or external clock counter mode
// - Two capture channels latch count, optional interrupt
// - Four match registers, interrupt, keep counting
// - Per match: optional stop on match
// - Per match: optional counter reset on match
// - Match outputs: low, high, toggle, nothing
// - PWM unit reuses timer with seven matches
// - Only PWM outputs leave the PWM unit
// - Match zero resets counter, sets period
// - One extra match places single edge
// - Each single-edge output needs one match
// - Single-edge outputs rise at period match
// - Rising and falling edges set independently
// - PWM unit has two capture inputs
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module timer_core #(
  parameter int NMATCH = timer_pkg::TIMER_MATCHES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         sel,
  input  wire logic                         wr,
  input  wire logic [timer_pkg::OFS_W-1:0]  addr,
  input  wire logic [31:0]                  wdata,
  input  wire logic                         extClk,
  input  wire logic [1:0]                   capIn,
  output logic      [31:0]                  readData,
  output logic                              irqLevel,
  output logic      [NMATCH-1:0]            matchOut,
  output logic      [NMATCH-1:1]            pwmOut
);
  typedef struct packed {
    logic [2:0]                ctrl;
    logic [31:0]               count;
    logic [31:0]               prescale;
    logic [31:0]               pscCount;
    logic [2*NMATCH-1:0]       matchCtrl;
    logic [3:0]                capCtrl;
    logic [15:0]               outCtrl;
    logic [15:0]               status;
    logic [15:0]               mask;
    logic [31:0]               cap0;
    logic [31:0]               cap1;
    logic [NMATCH-1:0][31:0]   match;
    logic [NMATCH-1:0]         extOut;
    logic [NMATCH-1:1]         pwm;
    logic                      extPrev;
    logic [1:0]                capPrev;
  } core_t;

  core_t             q;
  core_t             next_q;
  logic              tick;
  logic              pscWrap;
  logic              wrAny;
  logic [NMATCH-1:0] matchHit;
  logic [NMATCH-1:0] resetBits;
  logic [NMATCH-1:0] stopBits;
  logic [NMATCH-1:1] setEv;
  logic [NMATCH-1:1] clrEv;
  logic [NMATCH-1:1] dualBits;
  logic [1:0]        capEv;

  // Event decode from the present state
  always_comb begin
    wrAny = sel && wr;
    // Counter mode counts rising edges of the synchronised external clock
    tick = q.ctrl[timer_pkg::CTRL_RUN] && !q.ctrl[timer_pkg::CTRL_HOLD_RESET] &&
           (q.ctrl[timer_pkg::CTRL_COUNTER_MODE] ? (extClk && !q.extPrev) : 1'b1);
    pscWrap = tick && (q.pscCount == q.prescale);
    for (int i = 0; i < NMATCH; i++) begin
      matchHit[i]  = pscWrap && (q.count == q.match[i]);
      resetBits[i] = q.matchCtrl[timer_pkg::FIELD_STRIDE*i + timer_pkg::MC_RESET];
      stopBits[i]  = q.matchCtrl[timer_pkg::FIELD_STRIDE*i + timer_pkg::MC_STOP];
    end
    for (int k = 1; k < NMATCH; k++) begin
      dualBits[k] = q.outCtrl[timer_pkg::PWM_DUAL_LSB + k];
      // Double-edge output k rises on match k-1, single-edge on the period match
      setEv[k] = dualBits[k] ? matchHit[k-1] : matchHit[timer_pkg::PWM_PERIOD_MATCH];
      clrEv[k] = matchHit[k];
    end
    for (int c = 0; c < timer_pkg::N_CAPTURE; c++) begin
      capEv[c] = (q.capCtrl[timer_pkg::FIELD_STRIDE*c + timer_pkg::CC_RISE] && capIn[c] && !q.capPrev[c]) ||
                 (q.capCtrl[timer_pkg::FIELD_STRIDE*c + timer_pkg::CC_FALL] && !capIn[c] && q.capPrev[c]);
    end
  end

  // Next state: counting first, software writes last so a write wins over a tick
  always_comb begin
    next_q         = q;
    next_q.extPrev = extClk;
    next_q.capPrev = capIn;
    if (tick) begin
      next_q.pscCount = pscWrap ? timer_pkg::RST_WORD : q.pscCount + 32'h0000_0001;
    end
    if (pscWrap) begin
      if (|(matchHit & resetBits)) begin
        next_q.count = timer_pkg::RST_WORD;
      end else if (!(|(matchHit & stopBits))) begin
        next_q.count = q.count + 32'h0000_0001;
      end
      if (|(matchHit & stopBits)) begin
        next_q.ctrl[timer_pkg::CTRL_RUN] = 1'b0;
      end
    end
    if (q.ctrl[timer_pkg::CTRL_HOLD_RESET]) begin
      next_q.count    = timer_pkg::RST_WORD;
      next_q.pscCount = timer_pkg::RST_WORD;
    end
    // Match output actions
    for (int i = 0; i < NMATCH; i++) begin
      if (matchHit[i]) begin
        unique case (q.outCtrl[timer_pkg::FIELD_STRIDE*i +: 2])
          timer_pkg::ACT_NONE:   next_q.extOut[i] = q.extOut[i];
          timer_pkg::ACT_LOW:    next_q.extOut[i] = 1'b0;
          timer_pkg::ACT_HIGH:   next_q.extOut[i] = 1'b1;
          timer_pkg::ACT_TOGGLE: next_q.extOut[i] = !q.extOut[i];
        endcase
      end
    end
    // Set beats clear so a single-edge output always starts the period high
    for (int k = 1; k < NMATCH; k++) begin
      if (setEv[k]) begin
        next_q.pwm[k] = 1'b1;
      end else if (clrEv[k]) begin
        next_q.pwm[k] = 1'b0;
      end
    end
    // Captures
    if (capEv[0]) begin
      next_q.cap0 = q.count;
    end
    if (capEv[1]) begin
      next_q.cap1 = q.count;
    end
    // Sticky status: new events win over a write-one-to-clear in the same cycle
    if (wrAny && addr == timer_pkg::REG_STATUS) begin
      next_q.status = q.status & ~wdata[15:0];
    end
    next_q.status[NMATCH-1:0] = next_q.status[NMATCH-1:0] | matchHit;
    next_q.status[timer_pkg::CAP_STAT_LSB +: 2] = next_q.status[timer_pkg::CAP_STAT_LSB +: 2] | capEv;
    if (wrAny) begin
      unique case (addr)
        timer_pkg::REG_CTRL:       next_q.ctrl      = wdata[2:0];
        timer_pkg::REG_COUNT:      next_q.count     = wdata;
        timer_pkg::REG_PRESCALE:   next_q.prescale  = wdata;
        timer_pkg::REG_PSC_COUNT:  next_q.pscCount  = wdata;
        timer_pkg::REG_MATCH_CTRL: next_q.matchCtrl = wdata[2*NMATCH-1:0];
        timer_pkg::REG_CAP_CTRL:   next_q.capCtrl   = wdata[3:0];
        timer_pkg::REG_OUT_CTRL:   next_q.outCtrl   = wdata[15:0];
        timer_pkg::REG_MASK:       next_q.mask      = wdata[15:0];
        default: begin
          for (int i = 0; i < NMATCH; i++) begin
            if (addr == timer_pkg::REG_MATCH_BASE + 5'(i)) begin
              next_q.match[i] = wdata;
            end
          end
        end
      endcase
    end
  end

  // Read mux; reads have no side effects
  always_comb begin
    readData = timer_pkg::RST_WORD;
    unique case (addr)
      timer_pkg::REG_CTRL:       readData = {29'h0, q.ctrl};
      timer_pkg::REG_COUNT:      readData = q.count;
      timer_pkg::REG_PRESCALE:   readData = q.prescale;
      timer_pkg::REG_PSC_COUNT:  readData = q.pscCount;
      timer_pkg::REG_MATCH_CTRL: readData = 32'(q.matchCtrl);
      timer_pkg::REG_CAP_CTRL:   readData = {28'h0, q.capCtrl};
      timer_pkg::REG_OUT_CTRL:   readData = {16'h0, q.outCtrl};
      timer_pkg::REG_STATUS:     readData = {16'h0, q.status};
      timer_pkg::REG_MASK:       readData = {16'h0, q.mask};
      timer_pkg::REG_CAPTURE0:   readData = q.cap0;
      timer_pkg::REG_CAPTURE1:   readData = q.cap1;
      timer_pkg::REG_OUT_STATE:  readData = {16'h0, 8'(q.extOut), 8'({q.pwm, 1'b0})};
      default: begin
        for (int i = 0; i < NMATCH; i++) begin
          if (addr == timer_pkg::REG_MATCH_BASE + 5'(i)) begin
            readData = q.match[i];
          end
        end
      end
    endcase
  end

  // Unit outputs; disabled PWM channels sit low
  assign irqLevel = |(q.status & q.mask);
  assign matchOut = q.extOut;
  assign pwmOut   = q.pwm & q.outCtrl[NMATCH-1:1];

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_wrap;
    pscWrap && !wrAny;
  endsequence

  property p_psc_step;
    tick && !pscWrap && !wrAny |=> q.pscCount == $past(q.pscCount) + 32'h0000_0001;
  endproperty
  a_psc_step: assert property (p_psc_step) else $error("prescaler did not step");

  property p_count_step;
    s_wrap ##0 !(|(matchHit & (resetBits | stopBits))) |=> q.count == $past(q.count) + 32'h0000_0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance on wrap");

  property p_idle_hold;
    !tick && !wrAny && !q.ctrl[timer_pkg::CTRL_HOLD_RESET] |=> $stable(q.count) && $stable(q.pscCount);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counter moved without a tick");

  property p_capture;
    capEv[0] && !wrAny |=> q.cap0 == $past(q.count) && q.status[timer_pkg::CAP_STAT_LSB];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_match_flag;
    (|matchHit) |=> (q.status[NMATCH-1:0] & $past(matchHit)) == $past(matchHit);
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set");

  property p_stop;
    s_wrap ##0 (|(matchHit & stopBits)) |=> !q.ctrl[timer_pkg::CTRL_RUN] ##1 ($past(wrAny) || $stable(q.count));
  endproperty
  a_stop: assert property (p_stop) else $error("timer kept running after stop match");

  property p_reset;
    s_wrap ##0 (|(matchHit & resetBits)) |=> q.count == timer_pkg::RST_WORD;
  endproperty
  a_reset: assert property (p_reset) else $error("counter not cleared on reset match");

  property p_toggle;
    matchHit[0] && q.outCtrl[1:0] == timer_pkg::ACT_TOGGLE |=> q.extOut[0] != $past(q.extOut[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("match output did not toggle");

  property p_pwm_rise;
    matchHit[timer_pkg::PWM_PERIOD_MATCH] |=> (q.pwm & ~$past(dualBits)) == ~$past(dualBits);
  endproperty
  a_pwm_rise: assert property (p_pwm_rise) else $error("single-edge output not high at period");

  property p_pwm_fall;
    (|(clrEv & ~setEv)) |=> (q.pwm & $past(clrEv & ~setEv)) == '0;
  endproperty
  a_pwm_fall: assert property (p_pwm_fall) else $error("pwm output did not fall on its match");
endmodule

module timer_capture_match_pwm (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic [timer_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [31:0]                   regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [31:0]                   regRdata,
  output logic                               irq,
  input  wire logic [3:0]                    timerClkIn,
  input  wire logic [7:0]                    timerCaptureInput,
  input  wire logic                          pwmClkIn,
  input  wire logic [1:0]                    pwmCaptureInput,
  output logic      [15:0]                   timerMatchOutput,
  output logic      [5:0]                    pwmOut
);
  typedef struct packed {
    logic [timer_pkg::SYNC_W-1:0] sync1;
    logic [timer_pkg::SYNC_W-1:0] sync2;
    logic [31:0]                  rdata;
    logic                         irq;
    logic [15:0]                  matchOut;
    logic [5:0]                   pwm;
  } top_t;

  top_t        q;
  top_t        next_q;
  logic [4:0]  unitSel;
  logic [4:0]  unitIrq;
  logic [31:0] unitData [5];
  logic [15:0] timerMatch;
  logic [5:0]  pwmLevel;
  logic [2:0]  unitNum;

  assign unitNum = regAddr[7:5];

  // Four timers; their match outputs go to pins
  for (genvar t = 0; t < timer_pkg::N_TIMERS; t++) begin : g_timer
    assign unitSel[t] = (unitNum == 3'(t));
    timer_core #(.NMATCH(timer_pkg::TIMER_MATCHES)) u_timer (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .sel      (unitSel[t]),
      .wr       (regWr),
      .addr     (regAddr[4:0]),
      .wdata    (regWdata),
      .extClk   (q.sync2[t]),
      .capIn    (q.sync2[4 + 2*t +: 2]),
      .readData (unitData[t]),
      .irqLevel (unitIrq[t]),
      .matchOut (timerMatch[4*t +: 4]),
      .pwmOut   ()
    );
  end

  // PWM unit: same core with seven matches, only its PWM outputs are used
  assign unitSel[4] = (unitNum == timer_pkg::PWM_UNIT);
  timer_core #(.NMATCH(timer_pkg::PWM_MATCHES)) u_pwm (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .sel      (unitSel[4]),
    .wr       (regWr),
    .addr     (regAddr[4:0]),
    .wdata    (regWdata),
    .extClk   (q.sync2[12]),
    .capIn    (q.sync2[14:13]),
    .readData (unitData[4]),
    .irqLevel (unitIrq[4]),
    .matchOut (),
    .pwmOut   (pwmLevel)
  );

  // Pin synchronisers, read data, interrupt and pin outputs all registered
  always_comb begin
    next_q          = q;
    next_q.sync1    = {pwmCaptureInput, pwmClkIn, timerCaptureInput, timerClkIn};
    next_q.sync2    = q.sync1;
    next_q.rdata    = timer_pkg::RST_WORD;
    next_q.irq      = |unitIrq;
    next_q.matchOut = timerMatch;
    next_q.pwm      = pwmLevel;
    // Unused unit windows read as zero
    for (int u = 0; u < 5; u++) begin
      if (regRd && unitSel[u]) begin
        next_q.rdata = unitData[u];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign regRdata         = q.rdata;
  assign irq              = q.irq;
  assign timerMatchOutput = q.matchOut;
  assign pwmOut           = q.pwm;
endmodule

`default_nettype wire

// ==== design/timer_pkg.sv ====
// Constants shared by the timer, capture, match and PWM logic
package timer_pkg;
  // Unit and word counts
  localparam int DATA_W        = 32;
  localparam int ADDR_W        = 8;
  localparam int OFS_W         = 5;
  localparam int N_TIMERS      = 4;
  localparam int TIMER_MATCHES = 4;
  localparam int PWM_MATCHES   = 7;
  localparam int N_CAPTURE     = 2;
  localparam int SYNC_W        = 15;
  localparam logic [2:0] PWM_UNIT = 3'h4;

  // Word offsets inside one unit window (unit number in address bits 7:5)
  localparam logic [4:0] REG_CTRL       = 5'h00;
  localparam logic [4:0] REG_COUNT      = 5'h01;
  localparam logic [4:0] REG_PRESCALE   = 5'h02;
  localparam logic [4:0] REG_PSC_COUNT  = 5'h03;
  localparam logic [4:0] REG_MATCH_CTRL = 5'h04;
  localparam logic [4:0] REG_CAP_CTRL   = 5'h05;
  localparam logic [4:0] REG_OUT_CTRL   = 5'h06;
  localparam logic [4:0] REG_STATUS     = 5'h07;
  localparam logic [4:0] REG_MASK       = 5'h08;
  localparam logic [4:0] REG_CAPTURE0   = 5'h09;
  localparam logic [4:0] REG_CAPTURE1   = 5'h0A;
  localparam logic [4:0] REG_OUT_STATE  = 5'h0B;
  localparam logic [4:0] REG_MATCH_BASE = 5'h10;

  // Control bits
  localparam int CTRL_RUN          = 0;
  localparam int CTRL_COUNTER_MODE = 1;
  localparam int CTRL_HOLD_RESET   = 2;

  // Match control: two bits per match, capture control: two bits per channel
  localparam int MC_RESET     = 0;
  localparam int MC_STOP      = 1;
  localparam int CC_RISE      = 0;
  localparam int CC_FALL      = 1;
  localparam int FIELD_STRIDE = 2;

  // Match output actions, two bits per match in the output control word
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // PWM: enable of output k is bit k, double-edge mode of output k is bit 8+k
  localparam int PWM_DUAL_LSB     = 8;
  localparam int PWM_PERIOD_MATCH = 0;

  // Status and mask layout
  localparam int STAT_W       = 16;
  localparam int CAP_STAT_LSB = 8;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// ==== test/pin_stimulus.sv ====
// Far-side pin model: external count clocks and capture inputs
`timescale 1ns/10ps
`default_nettype none

module pin_stimulus (
  input  wire logic       sys_clk,
  output logic      [3:0] timerClkIn,
  output logic      [7:0] timerCaptureInput,
  output logic            pwmClkIn,
  output logic      [1:0] pwmCaptureInput
);
  // Pins idle low from time zero
  initial begin
    timerClkIn        = 4'h0;
    timerCaptureInput = 8'h00;
    pwmClkIn          = 1'b0;
    pwmCaptureInput   = 2'h0;
  end

  // Pulses three cycles wide so the two-flop synchroniser cannot miss one
  task automatic clock_pulses(input int unit, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (3) @(posedge sys_clk);
      if (unit == 4) pwmClkIn <= 1'b1; else timerClkIn[unit] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      if (unit == 4) pwmClkIn <= 1'b0; else timerClkIn[unit] <= 1'b0;
    end
  endtask

  // One rising edge on a capture pin; 0..7 timers, 8..9 PWM unit
  task automatic capture_rise(input int pin);
    @(posedge sys_clk);
    if (pin > 7) pwmCaptureInput[pin-8] <= 1'b1; else timerCaptureInput[pin] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    if (pin > 7) pwmCaptureInput[pin-8] <= 1'b0; else timerCaptureInput[pin] <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the timer, capture, match and PWM block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        irq;
  logic [3:0]  timerClkIn;
  logic [7:0]  timerCaptureInput;
  logic        pwmClkIn;
  logic [1:0]  pwmCaptureInput;
  logic [15:0] timerMatchOutput;
  logic [5:0]  pwmOut;
  int          numErrors = 0;
  int          testsRun  = 0;

  timer_capture_match_pwm dut (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
    .timerClkIn(timerClkIn), .timerCaptureInput(timerCaptureInput),
    .pwmClkIn(pwmClkIn), .pwmCaptureInput(pwmCaptureInput),
    .timerMatchOutput(timerMatchOutput), .pwmOut(pwmOut)
  );

  pin_stimulus pins (
    .sys_clk(sys_clk), .timerClkIn(timerClkIn), .timerCaptureInput(timerCaptureInput),
    .pwmClkIn(pwmClkIn), .pwmCaptureInput(pwmCaptureInput)
  );

  // 40 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] ra(input logic [2:0] u, input logic [4:0] o);
    return {u, o};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe; a gap edge follows so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Reset values, full-width registers, unmapped window
  task automatic test_regs;
    logic [31:0] d;
    rd(ra(3'h0, timer_pkg::REG_CTRL), d);         chk("ctrl reset", 32'h0, d);
    wr(ra(3'h5, 5'h01), 32'hFFFF_FFFF);
    rd(ra(3'h5, 5'h01), d);                       chk("unmapped read", 32'h0, d);
    wr(ra(3'h0, timer_pkg::REG_PRESCALE), 32'hFFFF_FFFF);
    rd(ra(3'h0, timer_pkg::REG_PRESCALE), d);     chk("prescale width", 32'hFFFF_FFFF, d);
    wr(ra(3'h0, 5'h13), 32'hA5A5_5A5A);
    rd(ra(3'h0, 5'h13), d);                       chk("match3 width", 32'hA5A5_5A5A, d);
    wr(ra(timer_pkg::PWM_UNIT, 5'h16), 32'h5A5A_A5A5);
    rd(ra(timer_pkg::PWM_UNIT, 5'h16), d);        chk("pwm match6", 32'h5A5A_A5A5, d);
  endtask

  // Nine external edges through a divide-by-three prescaler
  task automatic test_counter;
    logic [31:0] d;
    wr(ra(3'h2, timer_pkg::REG_PRESCALE), 32'h2);
    wr(ra(3'h2, timer_pkg::REG_CTRL), 32'h3);
    pins.clock_pulses(2, 9);
    wait_cyc(6);
    rd(ra(3'h2, timer_pkg::REG_COUNT), d);        chk("ext count", 32'h3, d);
    rd(ra(3'h2, timer_pkg::REG_PSC_COUNT), d);    chk("psc count", 32'h0, d);
    // Hold bit forces the counter to zero even while run is set
    wr(ra(3'h2, timer_pkg::REG_CTRL), 32'h5);
    rd(ra(3'h2, timer_pkg::REG_COUNT), d);        chk("held count", 32'h0, d);
  endtask

  // Reset-on-match loop, sticky status, mask and write-one-to-clear
  task automatic test_match_irq;
    logic [31:0] d;
    wr(ra(3'h0, timer_pkg::REG_PRESCALE), 32'h1);
    wr(ra(3'h0, timer_pkg::REG_MATCH_BASE), 32'h3);
    wr(ra(3'h0, timer_pkg::REG_MATCH_CTRL), 32'h1);
    wr(ra(3'h0, timer_pkg::REG_CTRL), 32'h1);
    wait_cyc(40);
    rd(ra(3'h0, timer_pkg::REG_STATUS), d);       chk("match flag", 32'h1, d & 32'h1);
    rd(ra(3'h0, timer_pkg::REG_COUNT), d);        chk("count bound", 32'h1, 32'(d <= 32'h3));
    chk("irq masked", 32'h0, 32'(irq));
    wr(ra(3'h0, timer_pkg::REG_MASK), 32'h1);
    wait_cyc(2);                                  chk("irq raised", 32'h1, 32'(irq));
    wr(ra(3'h0, timer_pkg::REG_CTRL), 32'h0);
    wr(ra(3'h0, timer_pkg::REG_STATUS), 32'hF);
    wait_cyc(2);                                  chk("irq cleared", 32'h0, 32'(irq));
    rd(ra(3'h0, timer_pkg::REG_STATUS), d);       chk("status cleared", 32'h0, d);
  endtask

  // Stop on match with all four output actions at once
  task automatic test_stop_outputs;
    logic [31:0] d;
    for (int i = 0; i < 4; i++) wr(ra(3'h1, 5'(16 + i)), 32'h5);
    wr(ra(3'h1, timer_pkg::REG_MATCH_CTRL), 32'h2);
    wr(ra(3'h1, timer_pkg::REG_OUT_CTRL), 32'h27);
    wr(ra(3'h1, timer_pkg::REG_CTRL), 32'h1);
    wait_cyc(20);
    rd(ra(3'h1, timer_pkg::REG_COUNT), d);        chk("stopped count", 32'h5, d);
    rd(ra(3'h1, timer_pkg::REG_CTRL), d);         chk("run cleared", 32'h0, d);
    chk("match pins", 32'h0050, 32'(timerMatchOutput));
  endtask

  // Capture of a known held count on a timer and on the PWM unit
  task automatic test_capture;
    logic [31:0] d;
    wr(ra(3'h3, timer_pkg::REG_COUNT), 32'h1234_5678);
    wr(ra(3'h3, timer_pkg::REG_CAP_CTRL), 32'h9);
    pins.capture_rise(6);
    rd(ra(3'h3, timer_pkg::REG_CAPTURE0), d);     chk("capture0", 32'h1234_5678, d);
    rd(ra(3'h3, timer_pkg::REG_STATUS), d);       chk("cap flag", 32'h100, d & 32'h300);
    // Channel 1 armed on the falling edge only
    pins.capture_rise(7);
    rd(ra(3'h3, timer_pkg::REG_CAPTURE1), d);     chk("capture1 fall", 32'h1234_5678, d);
    rd(ra(3'h3, timer_pkg::REG_STATUS), d);       chk("cap1 flag", 32'h300, d & 32'h300);
    wr(ra(timer_pkg::PWM_UNIT, timer_pkg::REG_COUNT), 32'h0BAD_F00D);
    wr(ra(timer_pkg::PWM_UNIT, timer_pkg::REG_CAP_CTRL), 32'h4);
    pins.capture_rise(9);
    rd(ra(timer_pkg::PWM_UNIT, timer_pkg::REG_CAPTURE1), d); chk("pwm cap1", 32'h0BAD_F00D, d);
    rd(ra(timer_pkg::PWM_UNIT, timer_pkg::REG_STATUS), d);   chk("pwm flag", 32'h200, d & 32'h300);
  endtask

  // Period 10: single-edge outputs 1 and 2 high 4 and 6, double-edge output 3 high 3
  task automatic test_pwm;
    int hi [3] = '{0, 0, 0};
    int ov = 0;
    wr(ra(timer_pkg::PWM_UNIT, timer_pkg::REG_COUNT), 32'h0);
    wr(ra(timer_pkg::PWM_UNIT, 5'h10), 32'h9);
    wr(ra(timer_pkg::PWM_UNIT, 5'h11), 32'h3);
    wr(ra(timer_pkg::PWM_UNIT, 5'h12), 32'h5);
    wr(ra(timer_pkg::PWM_UNIT, 5'h13), 32'h8);
    wr(ra(timer_pkg::PWM_UNIT, timer_pkg::REG_MATCH_CTRL), 32'h1);
    wr(ra(timer_pkg::PWM_UNIT, timer_pkg::REG_OUT_CTRL), 32'h80E);
    wr(ra(timer_pkg::PWM_UNIT, timer_pkg::REG_CTRL), 32'h1);
    wait_cyc(30);
    for (int c = 0; c < 100; c++) begin
      for (int k = 0; k < 3; k++) hi[k] += int'(pwmOut[k] === 1'b1);
      ov += int'(pwmOut[0] === 1'b1 && pwmOut[2] === 1'b1);
      wait_cyc(1);
    end
    chk("single edge", 32'd40, 32'(hi[0]));
    chk("second single edge", 32'd60, 32'(hi[1]));
    chk("double edge", 32'd30, 32'(hi[2]));
    chk("overlap", 32'd0, 32'(ov));
    chk("disabled outs", 32'h0, 32'(pwmOut[5:3]));
    chk("timer pins", 32'h0050, 32'(timerMatchOutput));
    wr(ra(timer_pkg::PWM_UNIT, timer_pkg::REG_CTRL), 32'h0);
  endtask

  // Hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #(25 * 20000);
    numErrors++;
    finish_test;
  end

  // Main sequence
  initial begin
    rst      = 1'b1;
    regAddr  = 8'h00;
    regWdata = 32'h0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    test_regs;
    test_counter;
    test_match_irq;
    test_stop_outputs;
    test_capture;
    test_pwm;
    finish_test;
  end
endmodule

`default_nettype wire
